// ===== design/motor_phase_filters.sv
/*
  phase state register with preload, current feedback filter and d event filter, behind an AHB-Lite slave.
  assumes pins asynchronous to CLOCK (two flop sync), one AHB-Lite master, word-wide single transfers.
*/
// Notes on behaviour
// RL1: input select 00 A, 01 B, 10 C, 11 encoder
// RL2: encoder mode feeds A/B digitally, bypasses mux
// RL3: preloaded bits take effect at next C event
// RL4: channel bits enable outputs unless override/dead-time
// RL5: partial write of non-preload bits clears preload
// RL6: page select bit 7 steers page 0/1
// RL7: soft reset bit returns all motor registers; phase mask keeps its value
// RL8: current event after N consecutive above-limit samples
// RL9: current samples taken at quarter bus clock
// RL10: blanking window at PWM turn-on, 0.5us steps
// RL11: comparator output ignored during current blanking
// RL12: blanking counted in bus clock cycles
// RL13: D event after selected consecutive D detections
// RL14: D blanking window starts at every C event; code starts it only outside sensor mode
// RL15: D samples on z clock, code+1, not sensor mode
// RL16: D window 5us steps then 20us; none in sensor mode
// RL17: soft reset bit clears itself after reset
// RL18: counters restart on invalid sample or blanking
module motor_phase_filters
  import motor_filter_pkg::*;
#(
  parameter int D_WINDOW_BITS = 10
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire ahb_request_t AHB_REQUEST,
  output ahb_answer_t AHB_ANSWER,
  input wire logic ROTOR_INPUT_A,
  input wire logic ROTOR_INPUT_B,
  input wire logic ROTOR_INPUT_C,
  input wire logic CURRENT_ABOVE_LIMIT,
  input wire logic D_DETECT,
  input wire logic C_EVENT,
  input wire logic PWM_ON,
  input wire logic Z_SAMPLE_CLOCK,
  input wire logic SENSOR_MODE_SELECT,
  input wire logic CHANNEL_OVERRIDE_BIT,
  input wire logic DEAD_TIME_ENABLE,
  output logic COMPARATOR_INPUT,
  output logic ENCODER_A,
  output logic ENCODER_B,
  output logic ENCODER_MODE,
  output logic [5:0] OUTPUT_CHANNEL_ON,
  output logic PAGE_SELECT,
  output logic CURRENT_EVENT,
  output logic D_EVENT
);
  initial begin
    if (D_WINDOW_BITS < 10 || D_WINDOW_BITS > 16) begin
      $error("D_WINDOW_BITS must hold 200 us of bus clock cycles");
    end
  end

  typedef struct packed {
    input_sync_t sync;
    logic [7:0] phase_state_reg;
    logic [7:0] phase_shadow;
    logic shadow_pending;
    logic [7:0] current_feedback_reg;
    logic [7:0] d_event_filter_reg;
    logic [7:0] phase_mask;
    logic [3:0] bus_div;
    logic [1:0] sample_div;
    logic [3:0] blank_count;
    logic [2:0] current_run;
    logic [D_WINDOW_BITS-1:0] d_blank_count;
    logic [3:0] d_run;
    logic data_phase;
    logic data_write;
    logic [7:0] data_addr;
    logic [31:0] read_data;
    logic current_event;
    logic d_event;
    logic comparator_input;
    logic encoder_a;
    logic encoder_b;
  } state_t;

  state_t state;
  state_t next_state;

  logic bus_tick;
  logic sample_tick;
  logic c_edge;
  logic pwm_edge;
  logic z_edge;
  logic current_blanked;
  logic d_blanked;
  logic [7:0] write_byte;
  logic [7:0] merged_phase;
  logic [3:0] blank_steps;
  logic [D_WINDOW_BITS-1:0] d_window_cycles;
  logic address_valid;

  assign bus_tick = state.bus_div == 4'(BUS_CLOCK_DIV - 1);
  assign sample_tick = bus_tick && state.sample_div == 2'(CURRENT_SAMPLE_DIV - 1); // RL9
  assign c_edge = state.sync.c_sync[1] && !state.sync.c_prev;
  assign pwm_edge = state.sync.pwm_sync[1] && !state.sync.pwm_prev;
  assign z_edge = state.sync.z_clock_sync[1] && !state.sync.z_prev;
  assign current_blanked = state.blank_count != 4'h0; // RL11
  assign d_blanked = state.d_blank_count != '0;
  assign write_byte = AHB_REQUEST.hwdata[7:0];
  assign address_valid = AHB_REQUEST.hsel && AHB_REQUEST.hready && AHB_REQUEST.htrans[1];
  // 0.5us is BLANK_STEP_CYCLES bus clock cycles per code
  assign blank_steps = 4'(state.current_feedback_reg[2:0] * BLANK_STEP_CYCLES); // RL10 RL12

  always_comb begin
    logic [3:0] code;
    code = state.d_event_filter_reg[3:0];
    if (!code[3]) begin
      d_window_cycles = D_WINDOW_BITS'((32'(code) + 32'd1) * D_STEP_SHORT_CYCLES); // RL16
    end else begin
      d_window_cycles = D_WINDOW_BITS'(32'd8 * D_STEP_SHORT_CYCLES
        + (32'(code) - 32'd7) * D_STEP_LONG_CYCLES); // RL16
    end
  end

  // whole-register write replaces preload; a masked write loads zero into the preload
  always_comb begin
    merged_phase = write_byte;
    if (state.phase_mask != 8'hff) begin
      merged_phase = (write_byte & state.phase_mask & 8'h00) | 8'h00; // RL5
    end
  end

  always_comb begin
    next_state = state;
    next_state.sync.rotor_sync_a = {state.sync.rotor_sync_a[0], ROTOR_INPUT_A};
    next_state.sync.rotor_sync_b = {state.sync.rotor_sync_b[0], ROTOR_INPUT_B};
    next_state.sync.rotor_sync_c = {state.sync.rotor_sync_c[0], ROTOR_INPUT_C};
    next_state.sync.current_sync = {state.sync.current_sync[0], CURRENT_ABOVE_LIMIT};
    next_state.sync.d_sync = {state.sync.d_sync[0], D_DETECT};
    next_state.sync.c_sync = {state.sync.c_sync[0], C_EVENT};
    next_state.sync.pwm_sync = {state.sync.pwm_sync[0], PWM_ON};
    next_state.sync.z_clock_sync = {state.sync.z_clock_sync[0], Z_SAMPLE_CLOCK};
    next_state.sync.c_prev = state.sync.c_sync[1];
    next_state.sync.pwm_prev = state.sync.pwm_sync[1];
    next_state.sync.z_prev = state.sync.z_clock_sync[1];

    next_state.bus_div = bus_tick ? 4'h0 : state.bus_div + 4'h1;
    if (bus_tick) begin
      next_state.sample_div = state.sample_div + 2'h1;
    end

    // preload transfer on the next C event
    if (c_edge && state.shadow_pending) begin
      next_state.phase_state_reg = state.phase_shadow; // RL3
      next_state.shadow_pending = 1'b0;
    end

    // comparator routing
    unique case (state.phase_state_reg[7:6])
      SELECT_A: next_state.comparator_input = state.sync.rotor_sync_a[1]; // RL1
      SELECT_B: next_state.comparator_input = state.sync.rotor_sync_b[1]; // RL1
      SELECT_C: next_state.comparator_input = state.sync.rotor_sync_c[1]; // RL1
      SELECT_ENCODER: next_state.comparator_input = 1'b0; // RL2
    endcase
    next_state.encoder_a = state.phase_state_reg[7:6] == SELECT_ENCODER && state.sync.rotor_sync_a[1]; // RL2
    next_state.encoder_b = state.phase_state_reg[7:6] == SELECT_ENCODER && state.sync.rotor_sync_b[1]; // RL2

    // current blanking at pwm turn-on
    if (pwm_edge && blank_steps != 4'h0) begin
      next_state.blank_count = blank_steps; // RL10
    end else if (current_blanked && bus_tick) begin
      next_state.blank_count = state.blank_count - 4'h1; // RL12
    end

    next_state.current_event = 1'b0;
    if (current_blanked) begin
      next_state.current_run = 3'h0; // RL18
    end else if (sample_tick) begin
      if (!state.sync.current_sync[1]) begin
        next_state.current_run = 3'h0; // RL18
      end else if (state.current_run == state.current_feedback_reg[5:3]) begin
        next_state.current_event = 1'b1; // RL8
        next_state.current_run = 3'h0;
      end else begin
        next_state.current_run = state.current_run + 3'h1; // RL8
      end
    end

    // d event filtering, off in sensor mode
    if (c_edge && !SENSOR_MODE_SELECT) begin
      next_state.d_blank_count = d_window_cycles; // RL14 RL16
    end else if (d_blanked && bus_tick) begin
      next_state.d_blank_count = state.d_blank_count - D_WINDOW_BITS'(1);
    end
    next_state.d_event = 1'b0;
    if (SENSOR_MODE_SELECT) begin
      next_state.d_run = 4'h0;
      next_state.d_event = state.sync.d_sync[1] && z_edge; // RL15
    end else if (d_blanked) begin
      next_state.d_run = 4'h0; // RL14 RL18
    end else if (z_edge) begin
      if (!state.sync.d_sync[1]) begin
        next_state.d_run = 4'h0; // RL18
      end else if (state.d_run == state.d_event_filter_reg[7:4]) begin
        next_state.d_event = 1'b1; // RL13 RL15
        next_state.d_run = 4'h0;
      end else begin
        next_state.d_run = state.d_run + 4'h1; // RL13
      end
    end

    // bus data phase
    if (state.data_phase && state.data_write) begin
      unique case (state.data_addr)
        PHASE_STATE_OFFSET: begin
          next_state.phase_shadow = merged_phase; // RL3 RL5
          next_state.shadow_pending = 1'b1;
        end
        CURRENT_FEEDBACK_OFFSET: next_state.current_feedback_reg = write_byte; // RL6
        D_EVENT_FILTER_OFFSET: next_state.d_event_filter_reg = write_byte;
        PHASE_MASK_OFFSET: next_state.phase_mask = write_byte;
        default: ;
      endcase
    end
    next_state.data_phase = address_valid;
    next_state.data_write = AHB_REQUEST.hwrite;
    next_state.data_addr = AHB_REQUEST.haddr[7:0];
    if (address_valid && !AHB_REQUEST.hwrite) begin
      unique case (AHB_REQUEST.haddr[7:0])
        PHASE_STATE_OFFSET: next_state.read_data = {24'h0, state.phase_state_reg};
        CURRENT_FEEDBACK_OFFSET: next_state.read_data = {24'h0, state.current_feedback_reg};
        D_EVENT_FILTER_OFFSET: next_state.read_data = {24'h0, state.d_event_filter_reg};
        PHASE_MASK_OFFSET: next_state.read_data = {24'h0, state.phase_mask};
        STATUS_OFFSET: next_state.read_data = {24'h0, 4'h0, state.shadow_pending, d_blanked,
          current_blanked, state.sync.current_sync[1]};
        default: next_state.read_data = 32'h0;
      endcase
    end

    // soft reset of phase, preload, current feedback and d filter registers (phase mask kept), bit then reads as zero
    if (state.current_feedback_reg[SOFT_RESET_BIT]) begin
      next_state.phase_state_reg = PHASE_STATE_RESET; // RL7
      next_state.phase_shadow = PHASE_STATE_RESET;
      next_state.shadow_pending = 1'b0;
      next_state.current_feedback_reg = CURRENT_FEEDBACK_RESET; // RL7 RL17
      next_state.d_event_filter_reg = D_EVENT_FILTER_RESET; // RL7
      next_state.blank_count = 4'h0;
      next_state.current_run = 3'h0;
      next_state.d_blank_count = '0;
      next_state.d_run = 4'h0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      state <= '0;
      state.phase_mask <= 8'hff;
    end else begin
      state <= next_state;
    end
  end

  assign AHB_ANSWER.hrdata = state.read_data;
  assign AHB_ANSWER.hreadyout = 1'b1;
  assign AHB_ANSWER.hresp = 1'b0;
  assign COMPARATOR_INPUT = state.comparator_input;
  assign ENCODER_A = state.encoder_a;
  assign ENCODER_B = state.encoder_b;
  assign ENCODER_MODE = state.phase_state_reg[7:6] == SELECT_ENCODER; // RL2
  // override and dead-time take the channels away from this register
  assign OUTPUT_CHANNEL_ON = (CHANNEL_OVERRIDE_BIT || DEAD_TIME_ENABLE) ? 6'h00
    : state.phase_state_reg[5:0]; // RL4
  assign PAGE_SELECT = state.current_feedback_reg[PAGE_SELECT_BIT]; // RL6
  assign CURRENT_EVENT = state.current_event;
  assign D_EVENT = state.d_event;
endmodule

// ===== design/motor_filter_pkg.sv
/*
  constants, register map and carrier types for the motor phase and event filter block.
  assumes a single 40 MHz clock and an AHB-Lite master with word accesses.
*/
package motor_filter_pkg;
  localparam logic [7:0] PHASE_STATE_OFFSET = 8'h00;
  localparam logic [7:0] CURRENT_FEEDBACK_OFFSET = 8'h04;
  localparam logic [7:0] D_EVENT_FILTER_OFFSET = 8'h08;
  localparam logic [7:0] PHASE_MASK_OFFSET = 8'h0c;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;
  localparam logic [7:0] PHASE_STATE_RESET = 8'h00;
  localparam logic [7:0] CURRENT_FEEDBACK_RESET = 8'h00;
  localparam logic [7:0] D_EVENT_FILTER_RESET = 8'h00;
  localparam int INPUT_SELECT_LSB = 6;
  localparam int PAGE_SELECT_BIT = 7;
  localparam int SOFT_RESET_BIT = 6;
  localparam int SAMPLE_COUNT_LSB = 3;
  localparam int D_COUNT_LSB = 4;
  localparam logic [1:0] SELECT_A = 2'h0;
  localparam logic [1:0] SELECT_B = 2'h1;
  localparam logic [1:0] SELECT_C = 2'h2;
  localparam logic [1:0] SELECT_ENCODER = 2'h3;
  // timing: figures in ns, step counts derived from the 250 ns bus clock period
  localparam int CLOCK_PERIOD_NS = 25;
  localparam int BUS_CLOCK_PERIOD_NS = 250;
  localparam int BUS_CLOCK_DIV = BUS_CLOCK_PERIOD_NS / CLOCK_PERIOD_NS;
  localparam int CURRENT_SAMPLE_DIV = 4;
  localparam int BLANK_STEP_NS = 500;
  localparam int BLANK_STEP_CYCLES = (BLANK_STEP_NS + BUS_CLOCK_PERIOD_NS - 1) / BUS_CLOCK_PERIOD_NS;
  localparam int D_STEP_SHORT_NS = 5000;
  localparam int D_STEP_LONG_NS = 20000;
  localparam int D_STEP_SHORT_CYCLES = (D_STEP_SHORT_NS + BUS_CLOCK_PERIOD_NS - 1) / BUS_CLOCK_PERIOD_NS;
  localparam int D_STEP_LONG_CYCLES = (D_STEP_LONG_NS + BUS_CLOCK_PERIOD_NS - 1) / BUS_CLOCK_PERIOD_NS;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic hready;
    logic [31:0] hwdata;
  } ahb_request_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ahb_answer_t;

  typedef struct packed {
    logic [1:0] rotor_sync_a;
    logic [1:0] rotor_sync_b;
    logic [1:0] rotor_sync_c;
    logic [1:0] current_sync;
    logic [1:0] d_sync;
    logic [1:0] c_sync;
    logic [1:0] pwm_sync;
    logic [1:0] z_clock_sync;
    logic c_prev;
    logic pwm_prev;
    logic z_prev;
  } input_sync_t;
endpackage

// ===== verification/motor_phase_filters_asserts.sv
/* checker for the phase and filter block.
   sees only top ports; bound at the foot. */
module motor_phase_filters_asserts
  import motor_filter_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire ahb_request_t AHB_REQUEST,
  input wire logic C_EVENT,
  input wire logic CURRENT_ABOVE_LIMIT,
  input wire logic D_DETECT,
  input wire logic CHANNEL_OVERRIDE_BIT,
  input wire logic DEAD_TIME_ENABLE,
  input wire logic COMPARATOR_INPUT,
  input wire logic ENCODER_A,
  input wire logic ENCODER_MODE,
  input wire logic [5:0] OUTPUT_CHANNEL_ON,
  input wire logic CURRENT_EVENT,
  input wire logic D_EVENT
);
  // cause history; sync latency may vary by a cycle
  logic [4:0] c_hist, t_hist, i_hist, d_hist;
  always_ff @(posedge CLOCK) begin
    c_hist <= {c_hist[3:0], C_EVENT};
    t_hist <= {t_hist[3:0], AHB_REQUEST.htrans[1]};
    i_hist <= {i_hist[3:0], CURRENT_ABOVE_LIMIT};
    d_hist <= {d_hist[3:0], D_DETECT};
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  enc_bypass_a: assert property (ENCODER_MODE && $past(ENCODER_MODE) |-> !COMPARATOR_INPUT)
    else $error("comparator driven in encoder mode");
  enc_off_a: assert property (!ENCODER_MODE && !$past(ENCODER_MODE) |-> !ENCODER_A)
    else $error("encoder a active outside encoder mode");
  preload_hold_a: assert property ($changed(ENCODER_MODE) |-> |c_hist[4:1] || |t_hist[4:1])
    else $error("select changed without c event");
  channel_mask_a: assert property (CHANNEL_OVERRIDE_BIT || DEAD_TIME_ENABLE |-> OUTPUT_CHANNEL_ON == 6'h00)
    else $error("channel on while masked");
  cur_pulse_a: assert property (CURRENT_EVENT |=> !CURRENT_EVENT)
    else $error("current event longer than a cycle");
  cur_cause_a: assert property (CURRENT_EVENT |-> |i_hist[4:2])
    else $error("current event without current");
  d_pulse_a: assert property (D_EVENT |=> !D_EVENT)
    else $error("d event longer than a cycle");
  d_cause_a: assert property (D_EVENT |-> |d_hist[4:2])
    else $error("d event without detection");
  cover property (CURRENT_EVENT);
  cover property (D_EVENT);
  cover property ($rose(ENCODER_MODE));
endmodule

bind motor_phase_filters motor_phase_filters_asserts i_asserts (.CLOCK(CLOCK), .RESET(RESET),
  .AHB_REQUEST(AHB_REQUEST), .C_EVENT(C_EVENT), .CURRENT_ABOVE_LIMIT(CURRENT_ABOVE_LIMIT),
  .D_DETECT(D_DETECT), .CHANNEL_OVERRIDE_BIT(CHANNEL_OVERRIDE_BIT), .DEAD_TIME_ENABLE(DEAD_TIME_ENABLE),
  .COMPARATOR_INPUT(COMPARATOR_INPUT), .ENCODER_A(ENCODER_A), .ENCODER_MODE(ENCODER_MODE),
  .OUTPUT_CHANNEL_ON(OUTPUT_CHANNEL_ON), .CURRENT_EVENT(CURRENT_EVENT), .D_EVENT(D_EVENT));

// ===== verification/motor_partner.sv
/* far side model: c event and pwm pulses, free z sample clock.
   assumes one-clock go strobes from the bench. */
module motor_partner (
  input wire logic clock,
  input wire logic c_go,
  input wire logic pwm_go,
  output logic c_event,
  output logic pwm_on,
  output logic z_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] c_left = 4'h0;
  logic [3:0] p_left = 4'h0;
  logic [3:0] z_div = 4'h0;
  // edges held several clocks so the two-flop sync sees them
  always @(posedge clock) begin
    c_left <= c_go ? 4'h6 : c_left - 4'(c_left != 4'h0);
    p_left <= pwm_go ? 4'h6 : p_left - 4'(p_left != 4'h0);
    z_div <= z_div + 4'h1;
  end
  assign c_event = c_left != 4'h0;
  assign pwm_on = p_left != 4'h0;
  assign z_clock = z_div[3];
endmodule

// ===== verification/tb_motor_phase_filters.sv
/* bench for the phase and filter block.
   assumes package, design, partner and checker compiled first. */
module tb_motor_phase_filters
  import motor_filter_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SP = BUS_CLOCK_DIV * CURRENT_SAMPLE_DIV;
  logic CLOCK = 1'b0, RESET = 1'b1, c_go = 1'b0, pwm_go = 1'b0;
  logic cur = 1'b0, dd = 1'b0, ovr = 1'b0, dead_time_enable = 1'b0, sm = 1'b0;
  logic [2:0] rot = 3'h0;
  logic c_ev, pwm, zc, ca, ea, eb, em, pg, ce, de;
  logic [5:0] oc;
  logic [31:0] rv;
  ahb_request_t req = '{hsize: 3'h2, hsel: 1'b1, default: '0};
  ahb_answer_t ans;
  int failures = 0, n_compared = 0, n_cur = 0, n_d = 0, cyc = 0, t, c0;
  always #12.5 CLOCK = ~CLOCK;
  always @* req.hready = ans.hreadyout;
  motor_phase_filters i_motor_phase_filters (.CLOCK(CLOCK), .RESET(RESET), .AHB_REQUEST(req),
    .AHB_ANSWER(ans), .ROTOR_INPUT_A(rot[0]), .ROTOR_INPUT_B(rot[1]), .ROTOR_INPUT_C(rot[2]),
    .CURRENT_ABOVE_LIMIT(cur), .D_DETECT(dd), .C_EVENT(c_ev), .PWM_ON(pwm), .Z_SAMPLE_CLOCK(zc),
    .SENSOR_MODE_SELECT(sm), .CHANNEL_OVERRIDE_BIT(ovr), .DEAD_TIME_ENABLE(dead_time_enable),
    .COMPARATOR_INPUT(ca), .ENCODER_A(ea), .ENCODER_B(eb), .ENCODER_MODE(em),
    .OUTPUT_CHANNEL_ON(oc), .PAGE_SELECT(pg), .CURRENT_EVENT(ce), .D_EVENT(de));
  motor_partner i_motor_partner (.clock(CLOCK), .c_go(c_go), .pwm_go(pwm_go), .c_event(c_ev),
    .pwm_on(pwm), .z_clock(zc));
  task give_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // event counters and hang guard; the run is well under two thousand cycles
  always @(posedge CLOCK) begin
    n_cur <= n_cur + int'(ce === 1'b1);
    n_d <= n_d + int'(de === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    req.haddr <= {24'h0, a};
    req.htrans <= 2'h2;
    req.hwrite <= w;
    @(posedge CLOCK);
    while (ans.hreadyout !== 1'b1) @(posedge CLOCK);
    req.htrans <= 2'h0;
    req.hwdata <= {24'h0, d};
    @(posedge CLOCK);
    while (ans.hreadyout !== 1'b1) @(posedge CLOCK);
    rv = ans.hrdata;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk("register read", {24'h0, e}, rv);
    chk("response", 0, ans.hresp);
  endtask
  task pulse_c;
    c_go <= 1'b1;
    @(posedge CLOCK);
    c_go <= 1'b0;
    repeat (12) @(posedge CLOCK);
  endtask
  initial begin
    repeat (16) @(posedge CLOCK);
    RESET <= 1'b0;
    @(posedge CLOCK);
    rd(PHASE_STATE_OFFSET, PHASE_STATE_RESET);
    rd(CURRENT_FEEDBACK_OFFSET, CURRENT_FEEDBACK_RESET);
    xfer(1'b1, 8'h40, 8'h55);
    rd(8'h40, 8'h00);
    xfer(1'b1, D_EVENT_FILTER_OFFSET, 8'h5a);
    xfer(1'b1, CURRENT_FEEDBACK_OFFSET, 8'h80);
    @(posedge CLOCK);
    chk("page select", 1, pg);
    xfer(1'b1, PHASE_STATE_OFFSET, 8'hc5);
    rd(PHASE_STATE_OFFSET, 8'h00);
    chk("early encoder mode", 0, em);
    rot <= 3'h1;
    pulse_c();
    rd(PHASE_STATE_OFFSET, 8'hc5);
    chk("encoder mode", 1, em);
    chk("encoder a b", 2'b01, {eb, ea});
    chk("comparator bypass", 0, ca);
    for (int m = 0; m < 4; m++) begin
      {dead_time_enable, ovr} <= 2'(m);
      repeat (2) @(posedge CLOCK);
      chk("channels on", m == 0 ? 6'h05 : 6'h00, oc);
    end
    {dead_time_enable, ovr} <= 2'h0;
    xfer(1'b1, CURRENT_FEEDBACK_OFFSET, 8'hc0);
    repeat (3) @(posedge CLOCK);
    rd(CURRENT_FEEDBACK_OFFSET, 8'h00);
    rd(D_EVENT_FILTER_OFFSET, 8'h00);
    rd(PHASE_STATE_OFFSET, 8'h00);
    chk("page after soft reset", 0, pg);
    for (int k = 0; k < 3; k++) begin
      xfer(1'b1, PHASE_STATE_OFFSET, {2'(k), 6'h00});
      pulse_c();
      for (int v = 0; v < 2; v++) begin
        rot <= v ? 3'(1 << k) : ~3'(1 << k);
        repeat (8) @(posedge CLOCK);
        chk("comparator input", v, ca);
      end
    end
    xfer(1'b1, PHASE_MASK_OFFSET, 8'hfe);
    xfer(1'b1, PHASE_STATE_OFFSET, 8'h7f);
    xfer(1'b1, PHASE_MASK_OFFSET, 8'hff);
    pulse_c();
    rd(PHASE_STATE_OFFSET, 8'h00);
    for (int k = 0; k < 8; k += 7) begin
      xfer(1'b1, CURRENT_FEEDBACK_OFFSET, 8'(k << SAMPLE_COUNT_LSB));
      cur <= 1'b1;
      t = 0;
      while (ce !== 1'b1 && t < 600) begin
        @(posedge CLOCK);
        t++;
      end
      chk("current delay", 1, t >= k * SP && t <= k * SP + 50);
      cur <= 1'b0;
      repeat (60) @(posedge CLOCK);
    end
    for (int b = 0; b < 8; b += 7) begin
      xfer(1'b1, CURRENT_FEEDBACK_OFFSET, 8'(b));
      c0 = n_cur;
      pwm_go <= 1'b1;
      @(posedge CLOCK);
      pwm_go <= 1'b0;
      // current raised only once the window has surely opened
      repeat (4) @(posedge CLOCK);
      cur <= 1'b1;
      repeat (96) @(posedge CLOCK);
      cur <= 1'b0;
      repeat (10) @(posedge CLOCK);
      chk("quiet while blanked", b == 7, n_cur == c0);
    end
    xfer(1'b1, D_EVENT_FILTER_OFFSET, 8'h30);
    c0 = n_d;
    dd <= 1'b1;
    pulse_c();
    repeat (130) @(posedge CLOCK);
    chk("d blanked", 1, n_d == c0);
    repeat (160) @(posedge CLOCK);
    chk("d passed", 1, n_d > c0);
    dd <= 1'b0;
    repeat (40) @(posedge CLOCK);
    c0 = n_d;
    dd <= 1'b1;
    repeat (40) @(posedge CLOCK);
    dd <= 1'b0;
    repeat (10) @(posedge CLOCK);
    chk("d short burst", 1, n_d == c0);
    xfer(1'b1, D_EVENT_FILTER_OFFSET, 8'hf0);
    sm <= 1'b1;
    c0 = n_d;
    dd <= 1'b1;
    pulse_c();
    repeat (40) @(posedge CLOCK);
    chk("sensor mode d pass", 1, n_d > c0);
    dd <= 1'b0;
    sm <= 1'b0;
    repeat (10) @(posedge CLOCK);
    give_verdict();
  end
endmodule
